// ---- hdl/descriptor_dma_control.v ----
/*
 control front of the descriptor dma: system control, poll demand,
 chain base registers, and a small master that fetches descriptors.
 assumes host register writes and reads arrive as same-clock strobes
 from the pci target logic, and a simple master port whose ack marks
 each data phase.
*/
// Notes on behaviour
// - tx burst bit makes tx descriptor bursts
// - rx burst bit makes rx descriptor bursts
// - read multiple set uses command 1100
// - read multiple clear uses command 0110
// - soft reset bit runs internal reset cycle
// - soft reset bit clears by itself
// - tx poll write polls tx descriptor
// - unowned tx descriptor suspends tx process
// - owned tx descriptor starts tx transfer
// - rx poll write polls rx descriptor
// - unowned rx descriptor suspends rx process
// - owned rx descriptor starts rx transfer
// - rx chain base is full 32 bits
// - poll after rx base write fetches base
// - tx chain base is full 32 bits
// - poll after tx base write fetches base
// - base registers are advanced working pointers
// - both resets restore register defaults
`timescale 1ns/10ps
`default_nettype none
`include "dma_ctrl_defs.vh"
module descriptor_dma_control #(
  parameter FIFO_DEPTH = 32,
  parameter FIFO_AW = 5
) (
  input wire ref_clk_i, // pci clock
  input wire rst_i, // hardware reset, async high
  input wire reg_wr_i, // register write strobe
  input wire reg_rd_i, // register read strobe
  input wire [6:0] reg_addr_i, // register byte offset
  input wire [31:0] reg_wdata_i, // write data
  output reg [31:0] reg_rdata_o, // read data
  output reg mst_req_o, // master request
  output reg [31:0] mst_addr_o, // master address
  output reg [3:0] mst_cmd_o, // c/be command
  output reg mst_burst_o, // burst transaction
  output reg [31:0] mst_wdata_o, // master write data
  input wire mst_ack_i, // data phase done
  input wire [31:0] mst_rdata_i, // master read data
  output reg tx_poll_strobe_o, // tx poll pulse
  output reg rx_poll_strobe_o, // rx poll pulse
  output reg tx_xfer_start_o, // tx buffer transfer start
  output reg rx_xfer_start_o, // rx buffer transfer start
  output reg tx_suspended_o, // tx process suspended
  output reg rx_suspended_o, // rx process suspended
  output reg soft_reset_o, // internal reset active
  output reg desc_valid_o, // descriptor word valid
  input wire desc_ready_i, // consumer takes word
  output reg [31:0] desc_data_o // descriptor word
);
  // engine states
  localparam ST_IDLE = 3'h0;
  localparam ST_FETCH = 3'h1;
  localparam ST_CHECK = 3'h2;
  localparam ST_CLOSE = 3'h3;

  reg tx_desc_burst_en_reg;
  reg rx_desc_burst_en_reg;
  reg read_multiple_sel_reg;
  reg [31:0] rx_chain_base_addr_reg;
  reg [31:0] tx_chain_base_addr_reg;
  reg tx_pend_reg;
  reg rx_pend_reg;
  reg [2:0] state_reg;
  reg chan_rx_reg;
  reg [2:0] word_reg;
  reg own_reg;
  reg [31:0] cur_addr_reg;
  wire sw_rst;
  wire soft_req;
  wire ctl_wr;
  wire tx_poll_wr;
  wire rx_poll_wr;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [31:0] fifo_out_data;
  wire fifo_push;
  wire fetching;
  reg [31:0] rdata_next;

  // choose the read command from the read multiple bit
  function [3:0] read_cmd;
    input sel;
    begin
      if (sel) begin
        read_cmd = `CMD_MEM_READ_MULT;
      end else begin
        read_cmd = `CMD_MEM_READ;
      end
    end
  endfunction

  // write decodes; data of poll writes is not looked at
  assign ctl_wr = reg_wr_i && (reg_addr_i == `OFF_SYSTEM_CONTROL);
  assign tx_poll_wr = reg_wr_i && (reg_addr_i == `OFF_TX_POLL);
  assign rx_poll_wr = reg_wr_i && (reg_addr_i == `OFF_RX_POLL);
  assign soft_req = ctl_wr && reg_wdata_i[`BIT_SOFT_RESET];

  // internal reset pulse, ends by itself
  soft_reset_gen #(
    .CYCLES(`SOFT_RESET_CYCLES)
  ) u_soft_reset (
    .clk_i(ref_clk_i),
    .rst_i(rst_i),
    .req_i(soft_req),
    .busy_o(sw_rst)
  );

  // fetched descriptor words buffered toward the consumer
  assign fetching = (state_reg == ST_FETCH);
  assign fifo_push = fetching && mst_req_o && mst_ack_i;
  desc_fifo #(
    .WIDTH(32),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk_i(ref_clk_i),
    .rst_i(rst_i),
    .flush_i(sw_rst),
    .in_valid_i(fifo_push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(mst_rdata_i),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(desc_ready_i || !desc_valid_o), // pop as output reg loads
    .out_data_o(fifo_out_data)
  );

  // system control bits; soft reset restores defaults
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_desc_burst_en_reg <= 1'b0;
      rx_desc_burst_en_reg <= 1'b0;
      read_multiple_sel_reg <= 1'b0;
    end else if (sw_rst) begin
      tx_desc_burst_en_reg <= 1'b0;
      rx_desc_burst_en_reg <= 1'b0;
      read_multiple_sel_reg <= 1'b0;
    end else if (ctl_wr) begin
      tx_desc_burst_en_reg <= reg_wdata_i[`BIT_TX_BURST];
      rx_desc_burst_en_reg <= reg_wdata_i[`BIT_RX_BURST];
      read_multiple_sel_reg <= reg_wdata_i[`BIT_READ_MULT];
    end
  end

  // pending poll flags: a new poll wins over the engine taking one
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_pend_reg <= 1'b0;
      rx_pend_reg <= 1'b0;
    end else if (sw_rst) begin
      tx_pend_reg <= 1'b0;
      rx_pend_reg <= 1'b0;
    end else begin
      if (tx_poll_wr) begin
        tx_pend_reg <= 1'b1;
      end else if (state_reg == ST_IDLE && !rx_pend_reg) begin
        tx_pend_reg <= 1'b0;
      end
      if (rx_poll_wr) begin
        rx_pend_reg <= 1'b1;
      end else if (state_reg == ST_IDLE) begin
        rx_pend_reg <= 1'b0;
      end
    end
  end

  // chain base registers: host writes set, engine advances
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_chain_base_addr_reg <= `BASE_RESET;
      tx_chain_base_addr_reg <= `BASE_RESET;
    end else if (sw_rst) begin
      rx_chain_base_addr_reg <= `BASE_RESET;
      tx_chain_base_addr_reg <= `BASE_RESET;
    end else begin
      if (reg_wr_i && reg_addr_i == `OFF_RX_BASE) begin
        rx_chain_base_addr_reg <= reg_wdata_i;
      end else if (state_reg == ST_CLOSE && chan_rx_reg && own_reg) begin
        rx_chain_base_addr_reg <= rx_chain_base_addr_reg + `DESC_STEP;
      end
      if (reg_wr_i && reg_addr_i == `OFF_TX_BASE) begin
        tx_chain_base_addr_reg <= reg_wdata_i;
      end else if (state_reg == ST_CLOSE && !chan_rx_reg && own_reg) begin
        tx_chain_base_addr_reg <= tx_chain_base_addr_reg + `DESC_STEP;
      end
    end
  end

  // fetch engine: read one descriptor, test own bit, report
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      chan_rx_reg <= 1'b0;
      word_reg <= 3'h0;
      own_reg <= 1'b0;
      cur_addr_reg <= `BASE_RESET;
      mst_req_o <= 1'b0;
      mst_addr_o <= `BASE_RESET;
      mst_cmd_o <= `CMD_MEM_READ;
      mst_burst_o <= 1'b0;
      mst_wdata_o <= `BASE_RESET;
      tx_xfer_start_o <= 1'b0;
      rx_xfer_start_o <= 1'b0;
      tx_suspended_o <= 1'b0;
      rx_suspended_o <= 1'b0;
    end else if (sw_rst) begin
      state_reg <= ST_IDLE;
      word_reg <= 3'h0;
      own_reg <= 1'b0;
      mst_req_o <= 1'b0;
      tx_xfer_start_o <= 1'b0;
      rx_xfer_start_o <= 1'b0;
      tx_suspended_o <= 1'b0;
      rx_suspended_o <= 1'b0;
    end else begin
      tx_xfer_start_o <= 1'b0;
      rx_xfer_start_o <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (rx_pend_reg || tx_pend_reg) begin
            chan_rx_reg <= rx_pend_reg;
            // fetch starts at the current base pointer
            if (rx_pend_reg) begin
              cur_addr_reg <= rx_chain_base_addr_reg;
              mst_addr_o <= rx_chain_base_addr_reg;
              mst_burst_o <= rx_desc_burst_en_reg;
            end else begin
              cur_addr_reg <= tx_chain_base_addr_reg;
              mst_addr_o <= tx_chain_base_addr_reg;
              mst_burst_o <= tx_desc_burst_en_reg;
            end
            mst_cmd_o <= read_cmd(read_multiple_sel_reg);
            mst_req_o <= 1'b1;
            word_reg <= 3'h0;
            state_reg <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (mst_ack_i && fifo_in_ready) begin
            if (word_reg == 3'h0) begin
              own_reg <= mst_rdata_i[`DESC_OWN_BIT];
            end
            word_reg <= word_reg + 3'h1;
            if (word_reg == `DESC_WORDS - 3'h1) begin
              mst_req_o <= 1'b0;
              state_reg <= ST_CHECK;
            end else if (!mst_burst_o) begin
              // single accesses: a new address phase per word
              cur_addr_reg <= cur_addr_reg + `WORD_STEP;
              mst_addr_o <= cur_addr_reg + `WORD_STEP;
            end
          end
        end
        ST_CHECK: begin
          if (own_reg) begin
            if (chan_rx_reg) begin
              rx_xfer_start_o <= 1'b1;
              rx_suspended_o <= 1'b0;
            end else begin
              tx_xfer_start_o <= 1'b1;
              tx_suspended_o <= 1'b0;
            end
          end else begin
            if (chan_rx_reg) begin
              rx_suspended_o <= 1'b1;
            end else begin
              tx_suspended_o <= 1'b1;
            end
          end
          state_reg <= ST_CLOSE;
        end
        ST_CLOSE: begin
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // read mux; poll registers read their fixed value
  always @* begin
    rdata_next = 32'h00000000;
    case (reg_addr_i)
      `OFF_SYSTEM_CONTROL: begin
        rdata_next = `SYSCTL_FIXED;
        rdata_next[`BIT_TX_BURST] = tx_desc_burst_en_reg;
        rdata_next[`BIT_RX_BURST] = rx_desc_burst_en_reg;
        rdata_next[`BIT_READ_MULT] = read_multiple_sel_reg;
      end
      `OFF_TX_POLL: rdata_next = `POLL_READ_VALUE;
      `OFF_RX_POLL: rdata_next = `POLL_READ_VALUE;
      `OFF_RX_BASE: rdata_next = rx_chain_base_addr_reg;
      `OFF_TX_BASE: rdata_next = tx_chain_base_addr_reg;
      default: rdata_next = 32'h00000000;
    endcase
  end

  // registered outputs
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h00000000;
      tx_poll_strobe_o <= 1'b0;
      rx_poll_strobe_o <= 1'b0;
      soft_reset_o <= 1'b0;
      desc_valid_o <= 1'b0;
      desc_data_o <= 32'h00000000;
    end else begin
      if (reg_rd_i) begin
        reg_rdata_o <= rdata_next;
      end
      tx_poll_strobe_o <= tx_poll_wr && !sw_rst;
      rx_poll_strobe_o <= rx_poll_wr && !sw_rst;
      soft_reset_o <= sw_rst;
      if (!desc_valid_o || desc_ready_i) begin
        desc_valid_o <= fifo_out_valid;
        desc_data_o <= fifo_out_data;
      end
    end
  end
endmodule // descriptor_dma_control
`default_nettype wire

// ---- hdl/dma_ctrl_defs.vh ----
/*
 constants for the descriptor dma control front: register offsets,
 field positions, reset values, bus commands and timing counts.
 assumes it is included by bare name from design files.
*/
`ifndef DMA_CTRL_DEFS_VH
`define DMA_CTRL_DEFS_VH

// register byte offsets from the csr base
`define OFF_SYSTEM_CONTROL 7'h00
`define OFF_TX_POLL 7'h08
`define OFF_RX_POLL 7'h10
`define OFF_RX_BASE 7'h18
`define OFF_TX_BASE 7'h20

// system control fields
`define BIT_TX_BURST 23
`define BIT_RX_BURST 22
`define BIT_READ_MULT 21
`define BIT_SOFT_RESET 0
`define SYSCTL_FIXED 32'hDE000000
`define POLL_READ_VALUE 32'h0FFFFFFF
`define BASE_RESET 32'h00000000

// pci bus commands
`define CMD_MEM_READ 4'h6
`define CMD_MEM_READ_MULT 4'hC
`define CMD_MEM_WRITE 4'h7

// descriptor layout: own bit of word 0, words per descriptor
`define DESC_OWN_BIT 31
`define DESC_WORDS 3'h4
`define DESC_STEP 32'h00000010
`define WORD_STEP 32'h00000004

// soft reset cycle length in pci clocks
`define SOFT_RESET_CYCLES 6'h20

`endif

// ---- hdl/desc_fifo.v ----
/*
 synchronous fifo for fetched descriptor words, width and depth set by
 parameters. assumes one clock, asynchronous active high reset, and a
 synchronous flush used for soft reset.
*/
`timescale 1ns/10ps
`default_nettype none
module desc_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clk_i, // clock
  input wire rst_i, // async reset
  input wire flush_i, // synchronous clear
  input wire in_valid_i, // write data valid
  output wire in_ready_o, // space available
  input wire [WIDTH-1:0] in_data_i, // write data
  output wire out_valid_o, // data available
  input wire out_ready_i, // reader takes word
  output wire [WIDTH-1:0] out_data_o // head word
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire do_wr;
  wire do_rd;

  // handshake terms and honest flags
  assign in_ready_o = (count_reg != DEPTH[AW:0]);
  assign out_valid_o = (count_reg != {(AW+1){1'b0}});
  assign do_wr = in_valid_i && in_ready_o;
  assign do_rd = out_ready_i && out_valid_o;
  assign out_data_o = mem[rd_ptr_reg];

  // storage write
  always @(posedge clk_i) begin
    if (do_wr) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  // pointers and occupancy
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else if (flush_i) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_rd) begin
        rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_wr && !do_rd) begin
        count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
      end else if (do_rd && !do_wr) begin
        count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // desc_fifo
`default_nettype wire

// ---- hdl/soft_reset_gen.v ----
/*
 soft reset sequencer: a request starts an internal reset pulse of a
 fixed number of clocks. assumes one clock and async active high reset.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dma_ctrl_defs.vh"
module soft_reset_gen #(
  parameter CYCLES = `SOFT_RESET_CYCLES
) (
  input wire clk_i, // clock
  input wire rst_i, // async reset
  input wire req_i, // one-cycle reset request
  output wire busy_o // internal reset active
);
  reg [5:0] count_reg;

  // counts down while the internal reset runs
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_reg <= 6'h00;
    end else if (req_i) begin
      count_reg <= CYCLES;
    end else if (count_reg != 6'h00) begin
      count_reg <= count_reg - 6'h01;
    end
  end
  assign busy_o = (count_reg != 6'h00);
endmodule // soft_reset_gen
`default_nettype wire

// ---- sim/descriptor_dma_control_checker.sv ----
/*
 port checker for descriptor_dma_control.
 assumes one clock and the bind at the foot of this file.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dma_ctrl_defs.vh"
module descriptor_dma_control_checker (
  input wire logic ref_clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic reg_wr_i, // write strobe
  input wire logic reg_rd_i, // read strobe
  input wire logic [6:0] reg_addr_i, // offset
  input wire logic [31:0] reg_wdata_i, // write data
  input wire logic [31:0] reg_rdata_o, // read data
  input wire logic mst_req_o, // request
  input wire logic [31:0] mst_addr_o, // address
  input wire logic [3:0] mst_cmd_o, // command
  input wire logic mst_burst_o, // burst
  input wire logic mst_ack_i, // ack
  input wire logic tx_poll_strobe_o, // tx poll
  input wire logic rx_poll_strobe_o, // rx poll
  input wire logic soft_reset_o // soft reset
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic [2:0] ctl_reg;
  logic [5:0] sr_cnt;
  // shadow of burst and read multiple bits, soft reset length
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_reg <= 3'h0;
      sr_cnt <= 6'h00;
    end else begin
      sr_cnt <= soft_reset_o ? sr_cnt + 6'h01 : 6'h00;
      if (reg_wr_i && reg_addr_i == `OFF_SYSTEM_CONTROL)
        ctl_reg <= reg_wdata_i[23:21];
      else if (soft_reset_o) ctl_reg <= 3'h0;
    end
  end
  sequence s_soft_write;
    reg_wr_i && reg_addr_i == `OFF_SYSTEM_CONTROL && reg_wdata_i[0]
      && !soft_reset_o;
  endsequence
  sequence s_reset_done;
    $fell(soft_reset_o) ##0 sr_cnt == 6'h20;
  endsequence
  a_soft_start: assert property (s_soft_write |-> ##[1:2] soft_reset_o)
    else $error("soft reset did not start");
  a_soft_length: assert property ($fell(soft_reset_o) |-> s_reset_done)
    else $error("soft reset length wrong");
  a_tx_poll: assert property (reg_wr_i && reg_addr_i == `OFF_TX_POLL
    && !soft_reset_o |=> tx_poll_strobe_o) else $error("no tx poll strobe");
  a_rx_poll: assert property (reg_wr_i && reg_addr_i == `OFF_RX_POLL
    && !soft_reset_o |=> rx_poll_strobe_o) else $error("no rx poll strobe");
  a_strobe_cause: assert property (tx_poll_strobe_o |->
    $past(reg_wr_i) && $past(reg_addr_i) == `OFF_TX_POLL)
    else $error("tx strobe without write");
  a_cmd_select: assert property (mst_req_o |-> mst_cmd_o ==
    (ctl_reg[0] ? `CMD_MEM_READ_MULT : `CMD_MEM_READ))
    else $error("wrong read command");
  a_burst_source: assert property (mst_req_o && mst_burst_o
    |-> ctl_reg[2] || ctl_reg[1]) else $error("burst without enable");
  a_req_holds: assert property (mst_req_o && !mst_ack_i && !soft_reset_o
    && !$past(reg_wr_i && reg_addr_i == `OFF_SYSTEM_CONTROL && reg_wdata_i[0])
    |=> mst_req_o && $stable(mst_addr_o)) else $error("request dropped");
  a_poll_read: assert property (reg_rd_i && (reg_addr_i == `OFF_TX_POLL
    || reg_addr_i == `OFF_RX_POLL) |=> reg_rdata_o == `POLL_READ_VALUE)
    else $error("poll read value wrong");
endmodule // descriptor_dma_control_checker
bind descriptor_dma_control descriptor_dma_control_checker chk (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .mst_req_o(mst_req_o),
  .mst_addr_o(mst_addr_o), .mst_cmd_o(mst_cmd_o),
  .mst_burst_o(mst_burst_o), .mst_ack_i(mst_ack_i),
  .tx_poll_strobe_o(tx_poll_strobe_o), .rx_poll_strobe_o(rx_poll_strobe_o),
  .soft_reset_o(soft_reset_o));
`default_nettype wire

// ---- sim/host_mem_model.sv ----
/*
 host memory behind the master port: acks each data phase, at full
 rate or every other cycle. assumes the request is held until acked.
*/
`timescale 1ns/10ps
`default_nettype none
module host_mem_model (
  input wire logic ref_clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic mst_req_i, // request
  input wire logic [31:0] mst_addr_i, // address
  input wire logic own_i, // own bit of word 0
  input wire logic slow_i, // ack every other cycle
  output logic mst_ack_o, // data phase done
  output logic [31:0] mst_rdata_o // read data
);
  logic go_reg;
  logic [31:0] last_reg;
  logic [2:0] beat_reg;
  logic [31:0] word;
  // word 0 carries own bit, the rest echo the address
  assign word = {beat_reg == 3'h0 ? own_i : 1'b0, mst_addr_i[30:0]};
  assign mst_ack_o = mst_req_i && (!slow_i || go_reg);
  // outside an ack the bus shows the inverse of the last word
  assign mst_rdata_o = mst_ack_o ? word : ~last_reg;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      go_reg <= 1'b0;
      last_reg <= 32'h00000000;
      beat_reg <= 3'h0;
    end else begin
      go_reg <= ~go_reg;
      if (mst_ack_o) last_reg <= word;
      beat_reg <= !mst_req_i ? 3'h0 : beat_reg + {2'h0, mst_ack_o};
    end
  end
endmodule // host_mem_model
`default_nettype wire

// ---- sim/descriptor_dma_control_test.sv ----
/*
 register level test of descriptor_dma_control with host memory model.
 assumes the checker is bound in by its own file.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dma_ctrl_defs.vh"
module descriptor_dma_control_test;
  logic ref_clk_i, rst_i, reg_wr_i, reg_rd_i, mst_ack_i, desc_ready_i;
  logic [6:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, mst_addr_o, mst_wdata_o;
  logic [31:0] mst_rdata_i, desc_data_o, txb, rxb, v;
  logic [3:0] mst_cmd_o;
  logic mst_req_o, mst_burst_o, tx_poll_strobe_o, rx_poll_strobe_o;
  logic tx_xfer_start_o, rx_xfer_start_o, tx_suspended_o, rx_suspended_o;
  logic soft_reset_o, desc_valid_o, own_r, slow_r;
  logic [2:0] ctl;
  int failures, checks_done, m, n;
  descriptor_dma_control dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .mst_req_o(mst_req_o), .mst_addr_o(mst_addr_o), .mst_cmd_o(mst_cmd_o),
    .mst_burst_o(mst_burst_o), .mst_wdata_o(mst_wdata_o),
    .mst_ack_i(mst_ack_i), .mst_rdata_i(mst_rdata_i),
    .tx_poll_strobe_o(tx_poll_strobe_o), .rx_poll_strobe_o(rx_poll_strobe_o),
    .tx_xfer_start_o(tx_xfer_start_o), .rx_xfer_start_o(rx_xfer_start_o),
    .tx_suspended_o(tx_suspended_o), .rx_suspended_o(rx_suspended_o),
    .soft_reset_o(soft_reset_o), .desc_valid_o(desc_valid_o),
    .desc_ready_i(desc_ready_i), .desc_data_o(desc_data_o));
  host_mem_model mem (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .mst_req_i(mst_req_o), .mst_addr_i(mst_addr_o), .own_i(own_r),
    .slow_i(slow_r), .mst_ack_o(mst_ack_i), .mst_rdata_o(mst_rdata_i));
  // clock and watchdog
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    #300000;
    failures++;
    tally_and_finish();
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    @(posedge ref_clk_i);
    #1 d = reg_rdata_o;
  endtask
  // one poll, fetch and descriptor check on a channel
  task automatic fetch(input logic rx, input logic own);
    logic seen, got;
    int i, k;
    seen = 1'b0;
    got = 1'b0;
    k = 0;
    @(posedge ref_clk_i);
    own_r <= own;
    wr(rx ? `OFF_RX_POLL : `OFF_TX_POLL, 32'h5A5A5A5A);
    for (i = 0; i < 80 && k < 3; i++) begin
      @(posedge ref_clk_i);
      #1;
      if (mst_req_o === 1'b1 && !seen) begin
        seen = 1'b1;
        chk(mst_addr_o, rx ? rxb : txb);
        chk(32'(mst_cmd_o), ctl[0] ? 32'hC : 32'h6);
        chk(32'(mst_burst_o), 32'(rx ? ctl[1] : ctl[2]));
        chk(mst_wdata_o, 32'h00000000);
      end
      if ((rx ? rx_xfer_start_o : tx_xfer_start_o) === 1'b1) got = 1'b1;
      if (seen && mst_req_o === 1'b0) k++;
    end
    chk(32'(got), 32'(own));
    chk(32'(rx ? rx_suspended_o : tx_suspended_o), 32'(!own));
    if (own && rx) rxb = rxb + `DESC_STEP;
    if (own && !rx) txb = txb + `DESC_STEP;
    rd(rx ? `OFF_RX_BASE : `OFF_TX_BASE, v);
    chk(v, rx ? rxb : txb);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    {reg_wr_i, reg_rd_i, own_r, slow_r, ctl} = '0;
    reg_addr_i = 7'h00;
    reg_wdata_i = 32'h00000000;
    desc_ready_i = 1'b1;
    rst_i = 1'b1;
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    // defaults, then unmapped offset 28 reads zero
    for (m = 0; m < 6; m++) begin
      rd(7'(8 * m), v);
      chk(v, m == 0 ? `SYSCTL_FIXED : m < 3 ? `POLL_READ_VALUE : 32'h0);
    end
    rxb = 32'h13579BD0;
    txb = 32'hFEDCBA90;
    wr(`OFF_RX_BASE, rxb);
    wr(`OFF_TX_BASE, txb);
    rd(`OFF_RX_BASE, v);
    chk(v, rxb);
    rd(`OFF_TX_BASE, v);
    chk(v, txb);
    // every burst and command choice, owned and unowned
    for (m = 0; m < 4; m++) begin
      ctl = {m[1], ~m[1], m[0]};
      slow_r <= m[0];
      wr(`OFF_SYSTEM_CONTROL, {8'h00, ctl, 21'h000000});
      rd(`OFF_SYSTEM_CONTROL, v);
      chk(v, `SYSCTL_FIXED | {8'h00, ctl, 21'h000000});
      fetch(1'b0, m[0]);
      fetch(1'b1, ~m[0]);
    end
    // fill the fifo with the consumer stalled, then drain it
    @(posedge ref_clk_i);
    desc_ready_i <= 1'b0;
    for (m = 0; m < 8; m++) fetch(1'b0, 1'b0);
    wr(`OFF_TX_POLL, 32'h00000000);
    repeat (30) @(posedge ref_clk_i);
    #1 chk(32'(mst_req_o), 32'h1);
    @(posedge ref_clk_i);
    desc_ready_i <= 1'b1;
    n = 0;
    // sample each cycle after its edge, the held word included
    repeat (200) begin
      #1;
      if (desc_valid_o === 1'b1 && n == 0)
        chk(desc_data_o, {1'b0, txb[30:0]});
      if (desc_valid_o === 1'b1) n++;
      @(posedge ref_clk_i);
    end
    chk(32'(n), 32'd36);
    // the soft reset write zeroes control, the internal reset clears the tx base by itself
    wr(`OFF_SYSTEM_CONTROL, 32'h00E00000);
    wr(`OFF_SYSTEM_CONTROL, 32'h00000001);
    repeat (34) @(posedge ref_clk_i);
    rd(`OFF_SYSTEM_CONTROL, v);
    chk(v, `SYSCTL_FIXED);
    rd(`OFF_TX_BASE, v);
    chk(v, `BASE_RESET);
    txb = `BASE_RESET;
    ctl = 3'h0;
    fetch(1'b0, 1'b1);
    tally_and_finish();
  end
endmodule // descriptor_dma_control_test
`default_nettype wire
